// File: rtl/dsac_pkg.sv
package dsac_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_CLKDIV = 8'h08;
  localparam logic [7:0] OFS_RES_L  = 8'h0C;
  localparam logic [7:0] OFS_RES_M  = 8'h10;
  localparam logic [7:0] OFS_RES_H  = 8'h14;
  localparam logic [7:0] OFS_CHAN   = 8'h18;
  localparam logic [7:0] OFS_PWR    = 8'h1C;
  localparam logic [7:0] OFS_INT    = 8'h20;

  // ==========================================================================
  // field positions
  localparam int unsigned C0_FRST   = 7;
  localparam int unsigned C0_SLP    = 6;
  localparam int unsigned C0_OFF    = 5;
  localparam int unsigned C0_OSR_LO = 2;
  localparam int unsigned C0_REFS   = 0;
  localparam int unsigned C1_FLM_LO = 5;
  localparam int unsigned C1_BUFN   = 4;
  localparam int unsigned C1_BUFP   = 3;
  localparam int unsigned C1_HOLD   = 2;
  localparam int unsigned C1_DONE   = 1;
  localparam int unsigned CH_POS_LO = 0;
  localparam int unsigned CH_NEG_LO = 4;
  localparam int unsigned PW_REGEN  = 0;
  localparam int unsigned IN_GIE    = 0;
  localparam int unsigned IN_CIE    = 1;
  localparam int unsigned IN_FLAG   = 2;

  // ==========================================================================
  // reset values and codes
  localparam logic [7:0] CTRL0_RST   = 8'h20;
  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [4:0] DIV_SEL_RST = 5'h00;
  localparam logic [4:0] DIV_BYPASS  = 5'h1F;
  localparam logic [2:0] CH_TSENSE   = 3'h7;
  localparam int unsigned RESULT_W   = 24;
  localparam int unsigned FILT_W_DEF = 28;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {MODE_PDOWN, MODE_SLEEP, MODE_RESET, MODE_NORMAL} dsac_mode_e;

  typedef struct packed {
    logic bandgap_on;
    logic regulator_on;
    logic vcm_on;
    logic pga_on;
    logic mod_on;
    logic tsense_on;
    logic vrn_buf_on;
    logic vrp_buf_on;
    logic sinc_on;
    logic sinc_reset;
    logic ref_ext_sel;
  } dsac_power_s;

  // priority decode: power off, then sleep, then filter reset
  function automatic dsac_mode_e dsac_mode(input logic off, input logic slp,
                                           input logic rst);
    if (off) begin
      return MODE_PDOWN;
    end else if (slp) begin
      return MODE_SLEEP;
    end else if (rst) begin
      return MODE_RESET;
    end
    return MODE_NORMAL;
  endfunction : dsac_mode

endpackage : dsac_pkg

// File: rtl/dsac_mclk_div.sv
`timescale 1ns/1ps
module dsac_mclk_div (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // divider select and tick out
  input  wire logic [4:0]            div_sel,
  output logic                       mclk_tick
);
  import dsac_pkg::*;

  logic [5:0] cnt_reg;
  logic [5:0] period_m1;

  // period is 2*(sel+1) cycles, so last count is 2*sel+1
  assign period_m1 = {div_sel, 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= 6'h00;
      mclk_tick <= 1'b0;
    end else if (div_sel == DIV_BYPASS) begin
      cnt_reg   <= 6'h00;
      mclk_tick <= 1'b1;
    end else if (cnt_reg >= period_m1) begin
      cnt_reg   <= 6'h00;
      mclk_tick <= 1'b1;
    end else begin
      cnt_reg   <= cnt_reg + 6'h01;
      mclk_tick <= 1'b0;
    end
  end

endmodule : dsac_mclk_div

// File: rtl/dsac_top.sv
// Function
// - hardware sets conversion-done flag at each conversion end; zero means converting.
// - done flag never self-clears; software writes zero before next detection.
// - five-bit divider gives sysclk/2/(code+1); code 11111 passes sysclk.
// - divider register bits 7..5 read zero; select resets to zero.
// - mode priority: power off, sleep, filter reset, else normal.
// - power down turns analog off; bandgap, regulator, vcm follow regulator enable.
// - sleep keeps bandgap, vcm, PGA, filter; modulator, sensor, buffers off.
// - temperature sensor powered in normal/reset only when a channel selects it.
// - in normal/reset each reference buffer follows its own enable bit.
// - software pulses filter reset; filter held while high, converts after.
// - each conversion end sets interrupt flag; request out when enabled.
// - conversion runs continuously, overwriting result with each new value.
// - hold enable keeps latest result and discards later ones.
// - reference pair select picks internal pair or external pins.
// - result is 24-bit two's complement, sign in the top bit.
// - result equals amplified input over amplified reference times two^23.
// - out-of-range inputs saturate at the positive or negative limit.
// - while holding, no interrupt and no done-flag change.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dsac_top #(
  parameter int unsigned FILT_W = dsac_pkg::FILT_W_DEF
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // decimation filter output
  input  wire logic                  filt_valid,
  input  wire logic [FILT_W-1:0]     filt_data,
  // analog and filter control
  output dsac_pkg::dsac_power_s      power,
  output logic                       mclk_tick,
  output logic [2:0]                 oversample_rate_sel,
  output logic [2:0]                 filter_clock_chop_sel,
  // interrupt request to cpu
  output logic                       int_req
);
  import dsac_pkg::*;

  typedef enum {CONV_IDLE, CONV_FRESET, CONV_RUN} dsac_conv_e;

  // the clamp and its check slice bits above the sign, so a guard bit is needed
  if (FILT_W <= RESULT_W) begin : g_chk
    $error("FILT_W must exceed RESULT_W");
  end

  localparam logic [RESULT_W-1:0] RES_MAX = {1'b0, {(RESULT_W-1){1'b1}}};
  localparam logic [RESULT_W-1:0] RES_MIN = {1'b1, {(RESULT_W-1){1'b0}}};

  // ==========================================================================
  // registers
  logic                filter_reset_ctl_reg;
  logic                sleep_ctl_reg;
  logic                power_off_ctl_reg;
  logic [2:0]          oversample_rate_sel_reg;
  logic                ref_pair_sel_reg;
  logic                neg_ref_buffer_en_reg;
  logic                pos_ref_buffer_en_reg;
  logic                result_hold_enable_reg;
  logic                conv_done_reg;
  logic [4:0]          mclk_div_sel_reg;
  logic [2:0]          pos_channel_sel_reg;
  logic [2:0]          neg_channel_sel_reg;
  logic                regulator_enable_reg;
  logic                global_int_enable_reg;
  logic                converter_int_enable_reg;
  logic                conv_irq_flag_reg;
  logic [RESULT_W-1:0] result_reg;
  dsac_conv_e          conv_state_reg;
  dsac_conv_e          conv_state_next;
  dsac_power_s         power_next;
  dsac_mode_e          mode;
  logic [31:0]         rd_next;
  logic                wr_en;
  logic                conv_end;
  logic                accept;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_CLKDIV) ||
           (a == OFS_RES_L) || (a == OFS_RES_M) || (a == OFS_RES_H) ||
           (a == OFS_CHAN) || (a == OFS_PWR) || (a == OFS_INT);
  endfunction : is_mapped

  function automatic logic [RESULT_W-1:0] sat_result(input logic [FILT_W-1:0] v);
    if ((&v[FILT_W-1:RESULT_W-1]) || !(|v[FILT_W-1:RESULT_W-1])) begin
      return v[RESULT_W-1:0];
    end
    return v[FILT_W-1] ? RES_MIN : RES_MAX;
  endfunction : sat_result

  // ==========================================================================
  // apb slave: one wait state, write lands on the pready edge
  assign wr_en = psel && penable && pready && pwrite && is_mapped(paddr);

  always_comb begin
    rd_next = 32'h0000_0000;
    case (paddr)
      OFS_CTRL0: begin
        rd_next[C0_FRST]            = filter_reset_ctl_reg;
        rd_next[C0_SLP]             = sleep_ctl_reg;
        rd_next[C0_OFF]             = power_off_ctl_reg;
        rd_next[C0_OSR_LO+:3]       = oversample_rate_sel_reg;
        rd_next[C0_REFS]            = ref_pair_sel_reg;
      end
      OFS_CTRL1: begin
        rd_next[C1_FLM_LO+:3]       = filter_clock_chop_sel;
        rd_next[C1_BUFN]            = neg_ref_buffer_en_reg;
        rd_next[C1_BUFP]            = pos_ref_buffer_en_reg;
        rd_next[C1_HOLD]            = result_hold_enable_reg;
        rd_next[C1_DONE]            = conv_done_reg;
      end
      OFS_CLKDIV: rd_next[4:0]      = mclk_div_sel_reg;
      OFS_RES_L:  rd_next[7:0]      = result_reg[7:0];
      OFS_RES_M:  rd_next[7:0]      = result_reg[15:8];
      OFS_RES_H:  rd_next[7:0]      = result_reg[23:16];
      OFS_CHAN: begin
        rd_next[CH_POS_LO+:3]       = pos_channel_sel_reg;
        rd_next[CH_NEG_LO+:3]       = neg_channel_sel_reg;
      end
      OFS_PWR:    rd_next[PW_REGEN] = regulator_enable_reg;
      OFS_INT: begin
        rd_next[IN_GIE]             = global_int_enable_reg;
        rd_next[IN_CIE]             = converter_int_enable_reg;
        rd_next[IN_FLAG]            = conv_irq_flag_reg;
      end
      default:    rd_next           = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
      if (psel && penable && !pready) begin
        prdata <= rd_next;
      end
    end
  end

  // ==========================================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {filter_reset_ctl_reg, sleep_ctl_reg, power_off_ctl_reg} <= CTRL0_RST[7:5];
      oversample_rate_sel_reg  <= CTRL0_RST[C0_OSR_LO+:3];
      ref_pair_sel_reg         <= CTRL0_RST[C0_REFS];
      filter_clock_chop_sel    <= CTRL1_RST[C1_FLM_LO+:3];
      neg_ref_buffer_en_reg    <= CTRL1_RST[C1_BUFN];
      pos_ref_buffer_en_reg    <= CTRL1_RST[C1_BUFP];
      result_hold_enable_reg   <= CTRL1_RST[C1_HOLD];
      mclk_div_sel_reg         <= DIV_SEL_RST;
      pos_channel_sel_reg      <= 3'h0;
      neg_channel_sel_reg      <= 3'h0;
      regulator_enable_reg     <= 1'b0;
      global_int_enable_reg    <= 1'b0;
      converter_int_enable_reg <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL0: begin
          filter_reset_ctl_reg    <= pwdata[C0_FRST];
          sleep_ctl_reg           <= pwdata[C0_SLP];
          power_off_ctl_reg       <= pwdata[C0_OFF];
          oversample_rate_sel_reg <= pwdata[C0_OSR_LO+:3];
          ref_pair_sel_reg        <= pwdata[C0_REFS];
        end
        OFS_CTRL1: begin
          filter_clock_chop_sel   <= pwdata[C1_FLM_LO+:3];
          neg_ref_buffer_en_reg   <= pwdata[C1_BUFN];
          pos_ref_buffer_en_reg   <= pwdata[C1_BUFP];
          result_hold_enable_reg  <= pwdata[C1_HOLD];
        end
        OFS_CLKDIV: mclk_div_sel_reg <= pwdata[4:0];
        OFS_CHAN: begin
          pos_channel_sel_reg     <= pwdata[CH_POS_LO+:3];
          neg_channel_sel_reg     <= pwdata[CH_NEG_LO+:3];
        end
        OFS_PWR: regulator_enable_reg <= pwdata[PW_REGEN];
        OFS_INT: begin
          global_int_enable_reg    <= pwdata[IN_GIE];
          converter_int_enable_reg <= pwdata[IN_CIE];
        end
        default: ;
      endcase
    end
  end

  assign oversample_rate_sel = oversample_rate_sel_reg;

  // ==========================================================================
  // mode decode and power gating
  // priority decode
  assign mode = dsac_mode(power_off_ctl_reg, sleep_ctl_reg, filter_reset_ctl_reg);

  always_comb begin
    power_next              = '0;
    power_next.regulator_on = regulator_enable_reg;
    power_next.ref_ext_sel  = ref_pair_sel_reg;
    case (mode)
      MODE_PDOWN: begin
        power_next.bandgap_on = regulator_enable_reg;
        power_next.vcm_on     = regulator_enable_reg;
      end
      MODE_SLEEP: begin
        power_next.bandgap_on = 1'b1;
        power_next.vcm_on     = 1'b1;
        power_next.pga_on     = 1'b1;
        power_next.sinc_on    = 1'b1;
      end
      default: begin
        power_next.bandgap_on = 1'b1;
        power_next.vcm_on     = 1'b1;
        power_next.pga_on     = 1'b1;
        power_next.mod_on     = 1'b1;
        power_next.sinc_on    = 1'b1;
        power_next.tsense_on  = (pos_channel_sel_reg == CH_TSENSE) ||
                                (neg_channel_sel_reg == CH_TSENSE);
        power_next.vrn_buf_on = neg_ref_buffer_en_reg;
        power_next.vrp_buf_on = pos_ref_buffer_en_reg;
        power_next.sinc_reset = (mode == MODE_RESET);
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power <= '0;
    end else begin
      power <= power_next;
    end
  end

  dsac_mclk_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .div_sel   (mclk_div_sel_reg),
    .mclk_tick (mclk_tick)
  );

  // ==========================================================================
  // conversion sequencing
  // start only after reset pulse
  always_comb begin
    conv_state_next = conv_state_reg;
    case (conv_state_reg)
      CONV_IDLE:   if (mode == MODE_RESET) conv_state_next = CONV_FRESET;
      CONV_FRESET: if (mode == MODE_NORMAL) conv_state_next = CONV_RUN;
      CONV_RUN:    if (mode == MODE_RESET) conv_state_next = CONV_FRESET;
      default:     conv_state_next = CONV_IDLE;
    endcase
    if (mode == MODE_PDOWN || mode == MODE_SLEEP) begin
      conv_state_next = CONV_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_state_reg <= CONV_IDLE;
    end else begin
      conv_state_reg <= conv_state_next;
    end
  end

  assign conv_end = (conv_state_reg == CONV_RUN) && (mode == MODE_NORMAL) && filt_valid;
  assign accept   = conv_end && !result_hold_enable_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
    end else if (accept) begin
      result_reg <= sat_result(filt_data);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_reg <= CTRL1_RST[C1_DONE];
    end else if (accept) begin
      conv_done_reg <= 1'b1;
    end else if (wr_en && paddr == OFS_CTRL1) begin
      conv_done_reg <= pwdata[C1_DONE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq_flag_reg <= 1'b0;
      int_req           <= 1'b0;
    end else begin
      if (accept) begin
        conv_irq_flag_reg <= 1'b1;
      end else if (wr_en && paddr == OFS_INT) begin
        conv_irq_flag_reg <= pwdata[IN_FLAG];
      end
      int_req <= conv_irq_flag_reg && global_int_enable_reg && converter_int_enable_reg;
    end
  end

  // ==========================================================================
  // assertions
  sequence s_tick_pair;
    !mclk_tick ##1 mclk_tick;
  endsequence

  done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> conv_done_reg) else $error("done flag not set");
  done_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    conv_done_reg && !(wr_en && paddr == OFS_CTRL1) |=> conv_done_reg)
    else $error("done flag cleared itself");
  div_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    mclk_div_sel_reg == 5'h00 && $stable(mclk_div_sel_reg) && mclk_tick
    ##1 mclk_div_sel_reg == 5'h00 |-> s_tick_pair) else $error("divide by two wrong");
  div_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    mclk_div_sel_reg == DIV_BYPASS [*2] |-> mclk_tick) else $error("bypass not every cycle");
  pdown_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    power_off_ctl_reg |=> !power.pga_on && !power.mod_on && !power.sinc_on &&
    power.bandgap_on == $past(regulator_enable_reg)) else $error("power down gating");
  sleep_pwr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !power_off_ctl_reg && sleep_ctl_reg |=> power.pga_on && power.sinc_on &&
    !power.mod_on && !power.tsense_on) else $error("sleep gating");
  freset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode == MODE_RESET |=> power.sinc_reset && conv_state_reg == CONV_FRESET)
    else $error("filter not held in reset");
  irq_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && global_int_enable_reg && converter_int_enable_reg |=> ##1 int_req)
    else $error("interrupt not raised");
  result_upd_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && filt_data[FILT_W-1:RESULT_W-1] == '0 |=> result_reg == $past(filt_data[RESULT_W-1:0]))
    else $error("result not updated");
  hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    result_hold_enable_reg && !conv_irq_flag_reg && !(wr_en && paddr == OFS_INT)
    |=> $stable(result_reg) && !conv_irq_flag_reg) else $error("hold not honoured");
  sat_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !filt_data[FILT_W-1] && |filt_data[FILT_W-2:RESULT_W-1]
    |=> result_reg == RES_MAX) else $error("positive clamp wrong");

endmodule : dsac_top

// File: test/test_delta_sigma_adc_control.sv
`timescale 1ns/1ps
module test_delta_sigma_adc_control;
  import dsac_pkg::*;
  // ==========================================================================
  // signals
  logic        pclk, presetn, psel, penable, pwrite, filt_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, mclk_tick, int_req;
  logic [27:0] filt_data;
  logic [2:0]  osr_q, chop_q;
  dsac_power_s pwr_q;
  int          err_total, tests_run;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [31:0] rows[6] = '{32'h00E07718, 32'h01E07718, 32'h00C07718,
                           32'h01010710, 32'h009470C8, 32'h01006600};
  logic [27:0] sat_in[4] = '{28'h7FFFFFF, 28'h8000000, 28'h0800000, 28'hF7FFFFF};
  logic [23:0] sat_out[4] = '{24'h7FFFFF, 24'h800000, 24'h7FFFFF, 24'h800000};
  int          codes[4] = '{0, 2, 30, 31};

  dsac_top #(.FILT_W(28)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_valid(filt_valid), .filt_data(filt_data), .power(pwr_q), .mclk_tick(mclk_tick),
    .oversample_rate_sel(osr_q), .filter_clock_chop_sel(chop_q), .int_req(int_req));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ==========================================================================
  // checking and bus tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one apb transfer; the expected answer is noted for the monitor
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] exp, input logic err);
    int n;
    notes.push_back({~wr, err, exp});
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 32'h0, 1'b0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask : rd

  always @(posedge pclk) begin
    if (presetn === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        err_total++;
        $display("BAD %0t: answer without request", $time);
      end else begin
        note = notes.pop_front();
        chk({31'h0, pslverr}, {31'h0, note[32]});
        if (note[33]) chk(prdata, note[31:0]);
      end
    end
  end

  task rres(input logic [23:0] e);
    rd(OFS_RES_L, {24'h0, e[7:0]});
    rd(OFS_RES_M, {24'h0, e[15:8]});
    rd(OFS_RES_H, {24'h0, e[23:16]});
  endtask : rres

  // two back-to-back filter results; only the second must survive
  task conv2(input logic [27:0] a, input logic [27:0] b);
    filt_valid <= 1'b1; filt_data <= a;
    @(posedge pclk);
    filt_data <= b;
    @(posedge pclk);
    filt_valid <= 1'b0; filt_data <= ~b;
    cyc(3);
  endtask : conv2

  task tick_per(input int p);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (mclk_tick !== 1'b1 && n < 200);
      if (n >= 200) begin
        err_total++;
        report_and_stop();
      end
    end
    chk(32'(n), 32'(p));
  endtask : tick_per

  function automatic dsac_power_s pexp(input logic rg, input logic [7:0] c0,
                                       input logic [7:0] ch, input logic [7:0] c1);
    dsac_power_s p;
    logic on, run;
    on = !c0[5];
    run = on && !c0[6];
    p.bandgap_on = on | rg; p.regulator_on = rg; p.vcm_on = on | rg;
    p.pga_on = on; p.mod_on = run; p.sinc_on = on;
    p.tsense_on = run && (ch[2:0] == CH_TSENSE || ch[6:4] == CH_TSENSE);
    p.vrn_buf_on = run & c1[4]; p.vrp_buf_on = run & c1[3];
    p.sinc_reset = run & c0[7]; p.ref_ext_sel = c0[0];
    return p;
  endfunction : pexp

  task mode(input logic rg, input logic [7:0] c0, input logic [7:0] ch, input logic [7:0] c1);
    logic [10:0] m;
    wr(OFS_PWR, {7'h0, rg}); wr(OFS_CHAN, ch); wr(OFS_CTRL1, c1); wr(OFS_CTRL0, c0);
    cyc(2);
    m = (!c0[5] && !c0[6] && c0[7]) ? 11'h7FB : 11'h7FF;
    chk(32'(pwr_q & m), 32'(pexp(rg, c0, ch, c1) & m));
    chk(32'({osr_q, chop_q}), 32'({c0[4:2], c1[7:5]}));
  endtask : mode

  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [27:0] d;
    logic [23:0] e;
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    filt_valid = 0; filt_data = 0; presetn = 0; err_total = 0; tests_run = 0;
    r = $urandom(91344);
    cyc(8);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(pwr_q), 32'h0);
    rd(OFS_CTRL0, 32'h20);
    rd(OFS_CTRL1, 32'h00);
    rd(OFS_CLKDIV, 32'h00);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CLKDIV, 8'(codes[k]) | 8'hE0);
      rd(OFS_CLKDIV, 32'(codes[k]));
      tick_per(codes[k] == 31 ? 1 : 2 * (codes[k] + 1));
    end
    apb(1'b1, 8'h40, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 10; i++) begin
      r = (i < 6) ? rows[i] : ($urandom & 32'h01FDFFF8);
      mode(r[24], r[23:16], r[15:8], r[7:0]);
    end
    // divider code 1 gives the nearest modulator clock to 4.9152 MHz from 20 MHz
    wr(OFS_PWR, 8'h01); wr(OFS_CLKDIV, 8'h01);
    wr(OFS_CTRL1, 8'h00); wr(OFS_INT, 8'h03); wr(OFS_CTRL0, 8'h80);
    conv2(28'h0000555, 28'h0000666);
    rd(OFS_CTRL1, 32'h00);
    wr(OFS_CTRL0, 8'h00);
    conv2(28'h0000777, 28'h0123456);
    rres(24'h123456);
    rd(OFS_CTRL1, 32'h02);
    rd(OFS_INT, 32'h07);
    chk(32'(int_req), 32'h1);
    cyc(30);
    rd(OFS_CTRL1, 32'h02);
    wr(OFS_RES_L, 8'hAB);
    rres(24'h123456);
    wr(OFS_INT, 8'h06);
    cyc(3);
    chk(32'(int_req), 32'h0);
    wr(OFS_INT, 8'h03);
    cyc(3);
    chk(32'(int_req), 32'h0);
    wr(OFS_CTRL1, 8'h00);
    rd(OFS_CTRL1, 32'h00);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      d = (i < 4) ? sat_in[i] : {{4{r[23]}}, r[23:0]};
      e = (i < 4) ? sat_out[i] : r[23:0];
      conv2(~d, d);
      rres(e);
    end
    wr(OFS_CTRL1, 8'h00); wr(OFS_INT, 8'h03); wr(OFS_CTRL1, 8'h04);
    conv2(28'h0000111, 28'h0000222);
    rres(e);
    rd(OFS_CTRL1, 32'h04);
    rd(OFS_INT, 32'h03);
    chk(32'(int_req), 32'h0);
    wr(OFS_CTRL1, 8'h00);
    conv2(28'h0000111, 28'h0000333);
    rres(24'h000333);
    rd(OFS_CTRL1, 32'h02);
    report_and_stop();
  end
endmodule : test_delta_sigma_adc_control
